// file: rtl/timer_pulse_pwm.sv
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
// How it works
// - One-pulse select enables pulse mode: capture one triggers, compare one ends.
// - Trigger edge: counter FFFC, pin gets level two, flag set, capture FFFD.
// - Counter equal to compare one drives level one, ending the pulse.
// - Capture flag clears after status read then capture low byte access.
// - One-pulse: first compare flag never set; second still set.
// - Both mode bits set gives pulse-width operation only.
// - Equal output levels hold the pin constant in both pulse modes.
// - One-pulse: no ordinary first capture; second capture still works.
// - One-pulse: second compare gives time flag only, no waveform.
// - Pulse-width: compare one drives level one, compare two level two.
// - Pulse-width: compare two match reloads counter with FFFC.
// - Level one high, two low: pulse length is compare two minus one.
// - Compare high byte write suspends compare until low byte write.
// - Pulse-width: neither compare flag is set.
// - Pulse-width: compare two match sets first capture flag.
// - Pulse-width: first capture pin disconnected; second capture usable.
// - Wait mode: timer runs, enabled event wakes the device.
// - Halt freezes counter; resumes from held count, reset restarts.
// - Capture edge in halt is captured at halt exit count.
// - Enables gate flag groups; wake from wait, never from halt.
// - One shared interrupt: enable set and CPU mask clear.
// - First edge select: zero falling, one rising.
// - Pin enable only routes waveform; compare logic always runs.
module timer_pulse_pwm
	import timer_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic first_capture_pin,
	input wire logic second_capture_pin,
	input wire logic ext_clock_pin,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	output logic first_compare_pin,
	output logic first_compare_pin_enable,
	output logic second_compare_pin,
	output logic second_compare_pin_enable,
	output logic timer_irq,
	output logic wait_wakeup
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] first_control_register;
	logic [7:0] second_control_register;
	logic [4:0] flags;
	logic [4:0] armed;
	logic [15:0] cnt;
	logic [15:0] first_capture_value;
	logic [15:0] second_capture_value;
	logic [15:0] first_compare_value;
	logic [15:0] second_compare_value;
	logic ic1_inh;
	logic ic2_inh;
	logic oc1_inh;
	logic oc2_inh;
	logic pend1;
	logic pend2;
	logic halt_q;
	logic [2:0] prescaler_factor;
	logic [2:0] ic1_s;
	logic [2:0] ic2_s;
	logic [2:0] ext_s;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire access = psel & penable;
	wire setup = psel & ~penable;
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	wire hit_cr1 = paddr == ADDR_CR1;
	wire hit_cr2 = paddr == ADDR_CR2;
	wire hit_sr = paddr == ADDR_SR;
	wire hit_ic1h = paddr == ADDR_IC1H;
	wire hit_ic1l = paddr == ADDR_IC1L;
	wire hit_oc1h = paddr == ADDR_OC1H;
	wire hit_oc1l = paddr == ADDR_OC1L;
	wire hit_cnth = paddr == ADDR_CNTH;
	wire hit_cntl = paddr == ADDR_CNTL;
	wire hit_ic2h = paddr == ADDR_IC2H;
	wire hit_ic2l = paddr == ADDR_IC2L;
	wire hit_oc2h = paddr == ADDR_OC2H;
	wire hit_oc2l = paddr == ADDR_OC2L;
	wire mapped = hit_cr1 | hit_cr2 | hit_sr | hit_ic1h | hit_ic1l | hit_oc1h
		| hit_oc1l | hit_cnth | hit_cntl | hit_ic2h | hit_ic2l | hit_oc2h | hit_oc2l;

	wire [7:0] read_byte =
		hit_cr1 ? first_control_register :
		hit_cr2 ? second_control_register :
		hit_sr ? {flags, 3'h0} :
		hit_ic1h ? first_capture_value[15:8] :
		hit_ic1l ? first_capture_value[7:0] :
		hit_oc1h ? first_compare_value[15:8] :
		hit_oc1l ? first_compare_value[7:0] :
		hit_cnth ? cnt[15:8] :
		hit_cntl ? cnt[7:0] :
		hit_ic2h ? second_capture_value[15:8] :
		hit_ic2l ? second_capture_value[7:0] :
		hit_oc2h ? second_compare_value[15:8] :
		hit_oc2l ? second_compare_value[7:0] : 8'h00;

	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// ----------------------------------------
	// Mode and control fields
	// ----------------------------------------
	// Pulse-width wins
	wire pwm_on = second_control_register[CR2_PWM];
	wire opm_on = second_control_register[CR2_OPM] & ~pwm_on;
	wire mode_t mode = pwm_on ? MODE_PWM : opm_on ? MODE_ONE_PULSE : MODE_NORMAL;
	wire normal = mode == MODE_NORMAL;
	wire first_output_level = first_control_register[CR1_FIRST_OUTPUT_LEVEL];
	wire second_output_level = first_control_register[CR1_SECOND_OUTPUT_LEVEL];
	wire [1:0] cc = second_control_register[CR2_CC_HI:CR2_CC_LO];

	// ----------------------------------------
	// Timer tick
	// ----------------------------------------
	logic [2:0] div_last;
	always_comb begin
		case (cc)
			CC_DIV2: div_last = DIV2_LAST;
			CC_DIV4: div_last = DIV4_LAST;
			CC_DIV8: div_last = DIV8_LAST;
			default: div_last = DIV4_LAST;
		endcase
	end

	wire run = ~halt_mode;
	wire prescaler_factor_tick = prescaler_factor == div_last;
	wire ext_tick = edge_seen(ext_s[1], ext_s[2], second_control_register[CR2_EXEDG]);
	wire tick = run & ((cc == CC_EXT) ? ext_tick : prescaler_factor_tick);
	wire halt_exit = halt_q & ~halt_mode;

	// ----------------------------------------
	// Events
	// ----------------------------------------
	// Edge polarity select
	wire ic1_edge = edge_seen(ic1_s[1], ic1_s[2], first_control_register[CR1_FIRST_CAPTURE_EDGE_SELECT]);
	wire ic2_edge = edge_seen(ic2_s[1], ic2_s[2], second_control_register[CR2_IEDG2]);
	wire trigger = opm_on & ic1_edge & run;
	// Ordinary first capture only in normal mode
	wire cap1 = normal & ~ic1_inh & ((ic1_edge & run) | (halt_exit & pend1));
	wire cap2 = ~ic2_inh & ((ic2_edge & run) | (halt_exit & pend2));
	wire match1 = tick & ~oc1_inh & (cnt == first_compare_value);
	wire match2 = tick & ~oc2_inh & (cnt == second_compare_value);
	wire pwm_reload = pwm_on & match2;
	wire reload = trigger | pwm_reload;
	wire ovf = tick & ~reload & (cnt == CNT_MAX);

	wire [15:0] next_cnt = reload ? CNT_RELOAD : tick ? cnt + 16'h0001 : cnt;

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	logic [4:0] set_vec;
	logic [4:0] clr_acc;
	always_comb begin
		set_vec = 5'h00;
		// Period end sets first capture flag
		set_vec[FL_FIRST_CAPTURE_FLAG] = cap1 | trigger | pwm_reload;
		set_vec[FL_FIRST_COMPARE_FLAG] = match1 & normal;
		set_vec[FL_SECOND_COMPARE_FLAG] = match2 & ~pwm_on;
		set_vec[FL_TOF] = ovf;
		set_vec[FL_SECOND_CAPTURE_FLAG] = cap2;
		clr_acc = 5'h00;
		clr_acc[FL_FIRST_CAPTURE_FLAG] = access & hit_ic1l;
		clr_acc[FL_FIRST_COMPARE_FLAG] = access & hit_oc1l;
		clr_acc[FL_TOF] = access & hit_cntl;
		clr_acc[FL_SECOND_CAPTURE_FLAG] = access & hit_ic2l;
		clr_acc[FL_SECOND_COMPARE_FLAG] = access & hit_oc2l;
	end

	wire [4:0] next_flags = set_vec | (flags & ~(armed & clr_acc));
	wire [4:0] next_armed = (rd & hit_sr) ? prdata[7:3] : (armed & ~clr_acc);

	// ----------------------------------------
	// Compare pins
	// ----------------------------------------
	logic next_pin1;
	always_comb begin
		if (!normal && first_output_level == second_output_level) begin
			next_pin1 = first_output_level;
		end else if (trigger || pwm_reload) begin
			// Level two at trigger or period
			next_pin1 = second_output_level;
		end else if (match1) begin
			next_pin1 = first_output_level;
		end else if (normal && first_control_register[CR1_FOLV1]) begin
			next_pin1 = first_output_level;
		end else begin
			next_pin1 = first_compare_pin;
		end
	end

	// Second pin waveform only in normal mode
	wire next_pin2 = (normal && (match2 || first_control_register[CR1_FOLV2]))
		? second_output_level : second_compare_pin;

	// ----------------------------------------
	// Interrupt and wake
	// ----------------------------------------
	// Enable groups
	wire enabled_event =
		(first_control_register[CR1_CAPTURE_INTERRUPT_ENABLE] & (flags[FL_FIRST_CAPTURE_FLAG] | flags[FL_SECOND_CAPTURE_FLAG])) |
		(first_control_register[CR1_COMPARE_INTERRUPT_ENABLE] & (flags[FL_FIRST_COMPARE_FLAG] | flags[FL_SECOND_COMPARE_FLAG])) |
		(first_control_register[CR1_OVERFLOW_INTERRUPT_ENABLE] & flags[FL_TOF]);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ic1_s <= 3'h0;
			ic2_s <= 3'h0;
			ext_s <= 3'h0;
			halt_q <= 1'b0;
		end else begin
			ic1_s <= {ic1_s[1:0], first_capture_pin};
			ic2_s <= {ic2_s[1:0], second_capture_pin};
			ext_s <= {ext_s[1:0], ext_clock_pin};
			halt_q <= halt_mode;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prescaler_factor <= 3'h0;
			cnt <= CNT_RESET;
			flags <= 5'h00;
			armed <= 5'h00;
			pend1 <= 1'b0;
			pend2 <= 1'b0;
		end else begin
			if (run) begin
				prescaler_factor <= prescaler_factor_tick ? 3'h0 : prescaler_factor + 3'h1;
			end
			cnt <= next_cnt;
			flags <= next_flags;
			armed <= next_armed;
			pend1 <= halt_mode & (pend1 | ic1_edge);
			pend2 <= halt_mode & (pend2 | ic2_edge);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			first_capture_value <= 16'h0000;
			second_capture_value <= 16'h0000;
		end else begin
			if (trigger) begin
				first_capture_value <= CAP_TRIGGER;
			end else if (cap1) begin
				first_capture_value <= cnt;
			end
			if (cap2) begin
				second_capture_value <= cnt;
			end
		end
	end

	// Capture transfer held off from high read to low read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ic1_inh <= 1'b0;
			ic2_inh <= 1'b0;
			oc1_inh <= 1'b0;
			oc2_inh <= 1'b0;
		end else begin
			ic1_inh <= (rd & hit_ic1h) | (ic1_inh & ~(rd & hit_ic1l));
			ic2_inh <= (rd & hit_ic2h) | (ic2_inh & ~(rd & hit_ic2l));
			oc1_inh <= (wr & hit_oc1h) | (oc1_inh & ~(wr & hit_oc1l));
			oc2_inh <= (wr & hit_oc2h) | (oc2_inh & ~(wr & hit_oc2l));
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			first_control_register <= CR_RESET;
			second_control_register <= CR_RESET;
			first_compare_value <= OC_RESET;
			second_compare_value <= OC_RESET;
		end else if (wr) begin
			if (hit_cr1) first_control_register <= pwdata[7:0];
			if (hit_cr2) second_control_register <= pwdata[7:0];
			if (hit_oc1h) first_compare_value[15:8] <= pwdata[7:0];
			if (hit_oc1l) first_compare_value[7:0] <= pwdata[7:0];
			if (hit_oc2h) second_compare_value[15:8] <= pwdata[7:0];
			if (hit_oc2l) second_compare_value[7:0] <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= {24'h000000, read_byte};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			first_compare_pin <= 1'b0;
			second_compare_pin <= 1'b0;
			first_compare_pin_enable <= 1'b0;
			second_compare_pin_enable <= 1'b0;
			timer_irq <= 1'b0;
			wait_wakeup <= 1'b0;
		end else begin
			first_compare_pin <= next_pin1;
			second_compare_pin <= next_pin2;
			first_compare_pin_enable <= second_control_register[CR2_FIRST_COMPARE_PIN_ENABLE];
			second_compare_pin_enable <= second_control_register[CR2_OC2E];
			timer_irq <= enabled_event & ~cpu_irq_mask;
			wait_wakeup <= enabled_event & ~halt_mode;
		end
	end

endmodule : timer_pulse_pwm

// file: rtl/timer_pkg.sv
package timer_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CR1 = 8'h00;
	localparam logic [7:0] ADDR_CR2 = 8'h04;
	localparam logic [7:0] ADDR_SR = 8'h08;
	localparam logic [7:0] ADDR_IC1H = 8'h0C;
	localparam logic [7:0] ADDR_IC1L = 8'h10;
	localparam logic [7:0] ADDR_OC1H = 8'h14;
	localparam logic [7:0] ADDR_OC1L = 8'h18;
	localparam logic [7:0] ADDR_CNTH = 8'h1C;
	localparam logic [7:0] ADDR_CNTL = 8'h20;
	localparam logic [7:0] ADDR_IC2H = 8'h24;
	localparam logic [7:0] ADDR_IC2L = 8'h28;
	localparam logic [7:0] ADDR_OC2H = 8'h2C;
	localparam logic [7:0] ADDR_OC2L = 8'h30;

	// ----------------------------------------
	// First control register fields
	// ----------------------------------------
	localparam int CR1_CAPTURE_INTERRUPT_ENABLE = 7;
	localparam int CR1_COMPARE_INTERRUPT_ENABLE = 6;
	localparam int CR1_OVERFLOW_INTERRUPT_ENABLE = 5;
	localparam int CR1_FOLV2 = 4;
	localparam int CR1_FOLV1 = 3;
	localparam int CR1_SECOND_OUTPUT_LEVEL = 2;
	localparam int CR1_FIRST_CAPTURE_EDGE_SELECT = 1;
	localparam int CR1_FIRST_OUTPUT_LEVEL = 0;

	// ----------------------------------------
	// Second control register fields
	// ----------------------------------------
	localparam int CR2_FIRST_COMPARE_PIN_ENABLE = 7;
	localparam int CR2_OC2E = 6;
	localparam int CR2_OPM = 5;
	localparam int CR2_PWM = 4;
	localparam int CR2_CC_HI = 3;
	localparam int CR2_CC_LO = 2;
	localparam int CR2_IEDG2 = 1;
	localparam int CR2_EXEDG = 0;

	// ----------------------------------------
	// Status flag vector, SR bits 7..3
	// ----------------------------------------
	localparam int FL_FIRST_CAPTURE_FLAG = 4;
	localparam int FL_FIRST_COMPARE_FLAG = 3;
	localparam int FL_TOF = 2;
	localparam int FL_SECOND_CAPTURE_FLAG = 1;
	localparam int FL_SECOND_COMPARE_FLAG = 0;

	// ----------------------------------------
	// Clock select codes and divider limits
	// ----------------------------------------
	localparam logic [1:0] CC_DIV4 = 2'h0;
	localparam logic [1:0] CC_DIV2 = 2'h1;
	localparam logic [1:0] CC_DIV8 = 2'h2;
	localparam logic [1:0] CC_EXT = 2'h3;
	localparam logic [2:0] DIV2_LAST = 3'h1;
	localparam logic [2:0] DIV4_LAST = 3'h3;
	localparam logic [2:0] DIV8_LAST = 3'h7;

	// ----------------------------------------
	// Values and reset values
	// ----------------------------------------
	localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] CAP_TRIGGER = 16'hFFFD;
	localparam logic [15:0] CNT_RESET = 16'hFFFC;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] OC_RESET = 16'h8000;
	localparam logic [7:0] CR_RESET = 8'h00;

	typedef enum logic [1:0] {MODE_NORMAL, MODE_ONE_PULSE, MODE_PWM} mode_t;

	function automatic logic edge_seen(input logic cur, input logic prev, input logic rise);
		edge_seen = rise ? (cur & ~prev) : (~cur & prev);
	endfunction : edge_seen

endpackage : timer_pkg

// file: verification/timer_chk.sv
`timescale 1ns/100ps
module timer_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	input wire logic first_compare_pin,
	input wire logic first_compare_pin_enable,
	input wire logic timer_irq,
	input wire logic wait_wakeup
);
	logic [7:0] ctl1;
	logic [7:0] ctl2;
	logic [7:0] age;
	wire acc = psel & penable;
	wire wr1 = acc & pwrite & (paddr == 8'h00);
	wire wr2 = acc & pwrite & (paddr == 8'h04);
	wire bad = acc & (paddr > 8'h30);
	// Shadow of both control bytes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) ctl1 <= 8'h00;
		else if (wr1) ctl1 <= pwdata[7:0];
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) ctl2 <= 8'h00;
		else if (wr2) ctl2 <= pwdata[7:0];
	end
	// Cycles since last control write, saturating
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) age <= 8'h00;
		else if (wr1 | wr2) age <= 8'h00;
		else if (age != 8'hFF) age <= age + 8'h01;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	property p_err; bad |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no slave error on unmapped access");
	property p_rzero; bad && !pwrite |-> prdata == 32'h0; endproperty
	a_rzero: assert property (p_rzero) else $error("unmapped read not zero");
	property p_irq_mask; $past(cpu_irq_mask) |-> !timer_irq; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
	property p_wake_halt; $past(halt_mode) |-> !wait_wakeup; endproperty
	a_wake_halt: assert property (p_wake_halt) else $error("wakeup in halt");
	property p_irq_en; age > 8'h04 && ctl1[7:5] == 3'h0 |-> !timer_irq; endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq with enables off");
	property p_pin_en; wr2 |-> ##2 first_compare_pin_enable == ctl2[7]; endproperty
	a_pin_en: assert property (p_pin_en) else $error("pin enable not routed");
	property p_equal;
		age == 8'hFF && ctl2[4] && ctl1[0] == ctl1[2] |-> first_compare_pin == ctl1[0];
	endproperty
	a_equal: assert property (p_equal) else $error("pin moved with equal levels");
	c_irq: cover property ($rose(timer_irq));
	c_err: cover property (bad && pslverr);
	c_pwm: cover property (age == 8'hFF && ctl2[4]);
endmodule : timer_chk

bind timer_pulse_pwm timer_chk chk (.clk(clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
	.first_compare_pin(first_compare_pin),
	.first_compare_pin_enable(first_compare_pin_enable), .timer_irq(timer_irq),
	.wait_wakeup(wait_wakeup));

// file: verification/pin_model.sv
`timescale 1ns/100ps
module pin_model (
	input wire logic clk,
	input wire logic first_compare_pin,
	output logic first_capture_pin,
	output logic second_capture_pin,
	output logic ext_clock_pin,
	output logic [7:0] width,
	output logic [7:0] n_pulses
);
	logic [7:0] run = 8'h00;
	initial begin
		first_capture_pin = 1'b0;
		second_capture_pin = 1'b0;
		ext_clock_pin = 1'b0;
		width = 8'h00;
		n_pulses = 8'h00;
	end
	// High time of the compare pin, in clocks
	always @(posedge clk) begin
		if (first_compare_pin === 1'b1) begin
			run <= run + 8'h01;
		end else if (run != 8'h00) begin
			width <= run;
			n_pulses <= n_pulses + 8'h01;
			run <= 8'h00;
		end
	end
	task automatic pulse(input logic which, input int hold);
		@(posedge clk);
		if (which) second_capture_pin <= 1'b1;
		else first_capture_pin <= 1'b1;
		repeat (hold) @(posedge clk);
		if (which) second_capture_pin <= 1'b0;
		else first_capture_pin <= 1'b0;
	endtask : pulse
endmodule : pin_model

// file: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic cpu_irq_mask = 1'b0;
	logic halt_mode = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, cap1, cap2, ext_clk, cmp1, cmp1_en, irq, wake, err_seen;
	logic [7:0] width, n_pulses, r, r2;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	timer_pulse_pwm dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .first_capture_pin(cap1), .second_capture_pin(cap2),
		.ext_clock_pin(ext_clk), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
		.first_compare_pin(cmp1), .first_compare_pin_enable(cmp1_en),
		.second_compare_pin(), .second_compare_pin_enable(), .timer_irq(irq),
		.wait_wakeup(wake));
	pin_model pm (.clk(clk), .first_compare_pin(cmp1), .first_capture_pin(cap1),
		.second_capture_pin(cap2), .ext_clock_pin(ext_clk), .width(width),
		.n_pulses(n_pulses));
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			n_errors++;
			$display("unexpected pready: expected 1 seen %b", pready);
		end
		r = prdata[7:0];
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle keeps the next setup from reusing this edge
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
	endtask : rd
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [7:0] addr [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h2C};
		logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80};
		for (int i = 0; i < 6; i++) begin
			rd(addr[i]);
			chk("reset_value", exp[i], r);
		end
		rd(8'h40);
		chk("unmapped_data", 8'h00, r);
		chk("unmapped_err", 8'h01, {7'h0, err_seen});
	endtask : t_reset
	task automatic t_one_pulse;
		logic [7:0] n0;
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h10);
		wr(8'h00, 8'h86);
		wr(8'h04, 8'hA4);
		n0 = n_pulses;
		pm.pulse(1'b0, 100);
		repeat (200) @(posedge clk);
		chk("pulse_count", n0 + 8'h01, n_pulses);
		chk("pulse_width", 8'h01, {7'h0, width >= 8'h26 && width <= 8'h2A});
		rd(8'h10);
		chk("cap_lo", 8'hFD, r);
		rd(8'h08);
		chk("status_pulse", 8'h80, r & 8'hD0);
		rd(8'h0C);
		chk("cap_hi", 8'hFF, r);
		rd(8'h10);
		rd(8'h08);
		chk("flag_cleared", 8'h00, r & 8'h80);
		pm.pulse(1'b1, 10);
		repeat (20) @(posedge clk);
		rd(8'h08);
		chk("second_capture", 8'h10, r & 8'h10);
	endtask : t_one_pulse
	task automatic t_pwm(input logic [7:0] mode);
		// Fresh reset so the counter restarts at FFFC, above both compare values
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h10);
		wr(8'h2C, 8'h00);
		wr(8'h30, 8'h30);
		wr(8'h00, 8'h81);
		wr(8'h04, mode);
		repeat (300) @(posedge clk);
		chk("high_width", 8'h40, width);
		rd(8'h08);
		chk("status_pwm", 8'h80, r & 8'hD8);
		chk("irq", 8'h01, {7'h0, irq});
	endtask : t_pwm
	task automatic t_low_power;
		cpu_irq_mask <= 1'b1;
		repeat (3) @(posedge clk);
		chk("irq_masked", 8'h00, {7'h0, irq});
		chk("wake", 8'h01, {7'h0, wake});
		halt_mode <= 1'b1;
		repeat (3) @(posedge clk);
		chk("wake_halt", 8'h00, {7'h0, wake});
		rd(8'h20);
		r2 = r;
		repeat (40) @(posedge clk);
		rd(8'h20);
		chk("frozen_count", r2, r);
		halt_mode <= 1'b0;
		cpu_irq_mask <= 1'b0;
		repeat (40) @(posedge clk);
		rd(8'h20);
		chk("count_resumes", 8'h01, {7'h0, r !== r2});
	endtask : t_low_power
	task automatic t_equal;
		int changes;
		changes = 0;
		wr(8'h00, 8'h05);
		repeat (300) @(posedge clk);
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			if (cmp1 !== 1'b1) begin
				changes++;
			end
		end
		chk("steady_level", 8'h00, changes[7:0]);
	endtask : t_equal
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_one_pulse();
		t_pwm(8'h94);
		t_low_power();
		t_pwm(8'hB4);
		t_equal();
		end_of_test();
	end
endmodule : testbench
